// file: src/cts_touch_scan.sv
// Purpose: capacitive touch scan sequencer, clocks, counter and registers
// Assumes: 50 MHz clk; comparator_in is asynchronous to clk
// Notes: fast clocks are approximated by phase accumulators on clk
//
// Overview of operation
// - go bit 0->1 launches scan, self-clears
// - clearing go mid-scan aborts at once
// - low-power select: 24M/2/(divider+2) clock
// - divider<=0x3c: 96M/2/(divider+8) clock
// - divider 3e/3f: random 1M..3M, centre 1.5M
// - gate-off bit stops switching clock
// - width code 0..7 gives 9..16 bits
// - count clock 24M/12M/6M/4M by select
// - precharge 20us or 40us
// - pre-discharge 2us or 10us
// - parallel bit scans all enabled channels
// - channel index valid 0-11, 16-47
// - raw count as two read-only bytes
// - pullup code is nine bits, high+low
// - port enable bit assigns pin to sensing
// - resistor select code 2=60k, 3=80k
// - threshold select 1.8V..4.2V in eight steps
// - front power-down bit keeps front-end off
// - scan completion raises an interrupt request
`timescale 1ns/10ps
module cts_touch_scan (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [7:0] sec_addr,
	input wire logic sec_wr,
	input wire logic sec_rd,
	input wire logic [7:0] sec_wdata,
	output logic [7:0] sec_rdata,
	input wire logic comparator_in,
	output logic switching_clock,
	output logic discharge_active,
	output logic precharge_active,
	output logic count_active,
	output logic [47:0] electrode_port_enable,
	output logic [47:0] scan_channel_mask,
	output logic [8:0] pullup_code,
	output logic [2:0] series_resistor_sel,
	output logic [2:0] threshold_voltage_sel,
	output logic touch_front_power_down,
	output logic scan_done_irq
);
	import cts_pkg::*;

	// -----------------------------------------------------------------
	// register storage
	// -----------------------------------------------------------------
	logic [7:0] system_clock_config;
	logic [7:0] pullup_low;
	logic [7:0] scan_cfg1;
	logic [7:0] scan_cfg2;
	logic [7:0] scan_cfg3;
	logic [7:0] port_reg [6];
	logic [7:0] ana_cfg;
	logic [7:0] pwr_down;
	logic scan_go;
	logic [15:0] raw_count;
	cts_state_type state;
	logic [11:0] phase_cnt;
	logic [16:0] win_cnt;
	logic [15:0] hit_cnt;
	logic cnt_tick;
	logic [6:0] cnt_acc;
	logic [12:0] sw_acc;
	logic [4:0] spread_cnt;
	logic [15:0] lfsr;
	logic cmp_meta;
	logic cmp_sync;

	// decoded fields
	logic low_power_front_clock_sel;
	logic front_clock_gate_off;
	logic [5:0] charge_clock_divider;
	logic parallel_scan;
	logic [5:0] sense_channel_index;
	logic [2:0] count_width_sel;
	logic [1:0] count_clock_sel;
	logic precharge_time_sel;
	logic initial_discharge_time_sel;
	logic chan_valid;
	logic go_write;
	logic launch;
	logic abort;
	logic [16:0] win_last;

	assign low_power_front_clock_sel = system_clock_config[LP_SEL_BIT];
	assign front_clock_gate_off = scan_cfg1[GATE_OFF_BIT];
	assign charge_clock_divider = scan_cfg1[5:0];
	assign parallel_scan = scan_cfg2[PARALLEL_BIT];
	assign sense_channel_index = scan_cfg2[5:0];
	assign count_width_sel = scan_cfg3[WIDTH_LSB +: 3];
	assign count_clock_sel = scan_cfg3[CNT_CLK_LSB +: 2];
	assign precharge_time_sel = scan_cfg3[PRECH_BIT];
	assign initial_discharge_time_sel = scan_cfg3[DISCH_BIT];
	// single-channel scans accept only the populated channel numbers
	assign chan_valid = (sense_channel_index <= CHAN_LOW_LAST) ||
		((sense_channel_index >= CHAN_HIGH_FIRST) && (sense_channel_index <= CHAN_HIGH_LAST));
	assign go_write = sfr_wr && (sfr_addr == SFR_SCAN_GO);
	assign launch = go_write && sfr_wdata[GO_BIT] && !scan_go && (parallel_scan || chan_valid);
	assign abort = go_write && !sfr_wdata[GO_BIT] && scan_go;
	// window is 2^(code+9) count clocks
	assign win_last = 17'((17'h00001 << (WIDTH_BASE + 32'(count_width_sel))) - 17'h00001);

	// -----------------------------------------------------------------
	// configuration writes
	// -----------------------------------------------------------------
	// sfr-side configuration registers, reserved bits held at zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			system_clock_config <= RST_ZERO;
			pullup_low <= RST_ZERO;
			scan_cfg1 <= RST_ZERO;
			scan_cfg2 <= RST_SCAN_CFG2;
			scan_cfg3 <= RST_SCAN_CFG3;
		end else if (sfr_wr) begin
			if (sfr_addr == SFR_SYS_CLK) begin
				system_clock_config <= sfr_wdata & MASK_SYS_CLK;
			end else if (sfr_addr == SFR_PULLUP_LOW) begin
				pullup_low <= sfr_wdata;
			end else if (sfr_addr == SFR_SCAN_CFG1) begin
				scan_cfg1 <= sfr_wdata & MASK_CFG1;
			end else if (sfr_addr == SFR_SCAN_CFG2) begin
				scan_cfg2 <= sfr_wdata;
			end else if (sfr_addr == SFR_SCAN_CFG3) begin
				scan_cfg3 <= sfr_wdata & MASK_CFG3;
			end
		end
	end

	// secondary-bus registers: port enables, analog config, power down
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 6; i++) begin
				port_reg[i] <= RST_ZERO;
			end
			ana_cfg <= RST_ANA_CFG;
			pwr_down <= RST_PWR_DOWN;
		end else if (sec_wr) begin
			if (sec_addr == SEC_PORT_0_7) begin
				port_reg[0] <= sec_wdata;
			end else if (sec_addr == SEC_PORT_8_11) begin
				port_reg[1] <= sec_wdata & MASK_PORT_8_11;
			end else if (sec_addr == SEC_PORT_16_23) begin
				port_reg[2] <= sec_wdata;
			end else if (sec_addr == SEC_PORT_24_31) begin
				port_reg[3] <= sec_wdata;
			end else if (sec_addr == SEC_PORT_32_39) begin
				port_reg[4] <= sec_wdata;
			end else if (sec_addr == SEC_PORT_40_47) begin
				port_reg[5] <= sec_wdata;
			end else if (sec_addr == SEC_ANA_CFG) begin
				ana_cfg <= sec_wdata & MASK_ANA_CFG;
			end else if (sec_addr == SEC_PWR_DOWN) begin
				pwr_down <= sec_wdata;
			end
		end
	end

	// analog settings go straight out of their registers
	assign electrode_port_enable = {port_reg[5], port_reg[4], port_reg[3], port_reg[2],
		4'h0, port_reg[1][3:0], port_reg[0]};
	assign pullup_code = {scan_cfg2[PULLUP_HIGH_BIT], pullup_low};
	assign series_resistor_sel = ana_cfg[RES_LSB +: 3];
	assign threshold_voltage_sel = ana_cfg[2:0];
	assign touch_front_power_down = pwr_down[FRONT_PD_BIT];

	// -----------------------------------------------------------------
	// register reads
	// -----------------------------------------------------------------
	// read data is captured on the strobe and held; unmapped reads zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sfr_rdata <= RST_ZERO;
		end else if (sfr_rd) begin
			if (sfr_addr == SFR_RAW_LOW) begin
				sfr_rdata <= raw_count[7:0];
			end else if (sfr_addr == SFR_RAW_HIGH) begin
				sfr_rdata <= raw_count[15:8];
			end else if (sfr_addr == SFR_SYS_CLK) begin
				sfr_rdata <= system_clock_config;
			end else if (sfr_addr == SFR_SCAN_GO) begin
				sfr_rdata <= {7'h00, scan_go};
			end else if (sfr_addr == SFR_PULLUP_LOW) begin
				sfr_rdata <= pullup_low;
			end else if (sfr_addr == SFR_SCAN_CFG1) begin
				sfr_rdata <= scan_cfg1;
			end else if (sfr_addr == SFR_SCAN_CFG2) begin
				sfr_rdata <= scan_cfg2;
			end else if (sfr_addr == SFR_SCAN_CFG3) begin
				sfr_rdata <= scan_cfg3;
			end else begin
				sfr_rdata <= RST_ZERO;
			end
		end
	end

	// secondary bus read port
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sec_rdata <= RST_ZERO;
		end else if (sec_rd) begin
			if (sec_addr == SEC_PORT_0_7) begin
				sec_rdata <= port_reg[0];
			end else if (sec_addr == SEC_PORT_8_11) begin
				sec_rdata <= port_reg[1];
			end else if (sec_addr == SEC_PORT_16_23) begin
				sec_rdata <= port_reg[2];
			end else if (sec_addr == SEC_PORT_24_31) begin
				sec_rdata <= port_reg[3];
			end else if (sec_addr == SEC_PORT_32_39) begin
				sec_rdata <= port_reg[4];
			end else if (sec_addr == SEC_PORT_40_47) begin
				sec_rdata <= port_reg[5];
			end else if (sec_addr == SEC_ANA_CFG) begin
				sec_rdata <= ana_cfg;
			end else if (sec_addr == SEC_PWR_DOWN) begin
				sec_rdata <= pwr_down;
			end else begin
				sec_rdata <= RST_ZERO;
			end
		end
	end

	// -----------------------------------------------------------------
	// scan start bit and sequencer
	// -----------------------------------------------------------------
	// go bit: set by a valid launch, cleared by software or at scan end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scan_go <= 1'b0;
		end else if (launch) begin
			scan_go <= 1'b1;
		end else if (abort || state == ST_DONE) begin
			scan_go <= 1'b0;
		end
	end

	// phase sequencer: discharge, precharge, count window, done
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			phase_cnt <= 12'h000;
		end else if (abort) begin
			state <= ST_IDLE;
			phase_cnt <= 12'h000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (launch) begin
						state <= ST_DISCH;
						phase_cnt <= (initial_discharge_time_sel ? DISCH_LONG_CYC : DISCH_SHORT_CYC) - 12'h001;
					end
				end
				ST_DISCH: begin
					if (phase_cnt == 12'h000) begin
						state <= ST_PRECH;
						phase_cnt <= (precharge_time_sel ? PRECH_LONG_CYC : PRECH_SHORT_CYC) - 12'h001;
					end else begin
						phase_cnt <= phase_cnt - 12'h001;
					end
				end
				ST_PRECH: begin
					if (phase_cnt == 12'h000) begin
						state <= ST_COUNT;
					end else begin
						phase_cnt <= phase_cnt - 12'h001;
					end
				end
				ST_COUNT: begin
					if (cnt_tick && win_cnt == win_last) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// phase indications for the analog front end
	assign discharge_active = state[1];
	assign precharge_active = state[2];
	assign count_active = state[3];

	// channel routing latched at launch: all enabled or the one selected
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scan_channel_mask <= 48'h000000000000;
		end else if (abort || state == ST_DONE) begin
			scan_channel_mask <= 48'h000000000000;
		end else if (launch) begin
			scan_channel_mask <= parallel_scan ? electrode_port_enable :
				(48'h000000000001 << sense_channel_index);
		end
	end

	// -----------------------------------------------------------------
	// count clock and capacitance counter
	// -----------------------------------------------------------------
	// comparator synchroniser
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= comparator_in;
			cmp_sync <= cmp_meta;
		end
	end

	// phase accumulator gives the selected count clock rate on average
	always_ff @(posedge clk or posedge sys_rst) begin
		logic [6:0] rate;
		logic [7:0] sum;
		if (sys_rst) begin
			cnt_acc <= 7'h00;
			cnt_tick <= 1'b0;
		end else begin
			case (count_clock_sel)
				2'b00: rate = CNT_RATE_0;
				2'b01: rate = CNT_RATE_1;
				2'b10: rate = CNT_RATE_2;
				default: rate = CNT_RATE_3;
			endcase
			sum = {1'b0, cnt_acc} + {1'b0, rate};
			if (state != ST_COUNT) begin
				cnt_acc <= 7'h00;
				cnt_tick <= 1'b0;
			end else if (sum >= 8'(CLK_MHZ)) begin
				cnt_acc <= 7'(sum - 8'(CLK_MHZ));
				cnt_tick <= 1'b1;
			end else begin
				cnt_acc <= sum[6:0];
				cnt_tick <= 1'b0;
			end
		end
	end

	// window counter and hit counter; last tick is not counted, so
	// the result fits the selected width
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			win_cnt <= 17'h00000;
			hit_cnt <= 16'h0000;
		end else if (state != ST_COUNT) begin
			win_cnt <= 17'h00000;
			hit_cnt <= 16'h0000;
		end else if (cnt_tick && win_cnt != win_last) begin
			win_cnt <= win_cnt + 17'h00001;
			hit_cnt <= hit_cnt + {15'h0000, cmp_sync};
		end
	end

	// raw count captured only at scan completion
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			raw_count <= 16'h0000;
		end else if (state == ST_DONE) begin
			raw_count <= hit_cnt;
		end
	end

	// one-cycle completion request toward the interrupt controller
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scan_done_irq <= 1'b0;
		end else begin
			scan_done_irq <= (state == ST_DONE);
		end
	end

	// -----------------------------------------------------------------
	// switching clock
	// -----------------------------------------------------------------
	// lfsr feeds the spread-spectrum half-period choice
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lfsr <= LFSR_SEED;
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	// fixed modes by accumulator, spread mode by random half periods
	always_ff @(posedge clk or posedge sys_rst) begin
		logic [12:0] step;
		logic [12:0] limit;
		logic [12:0] sum;
		if (sys_rst) begin
			sw_acc <= 13'h0000;
			spread_cnt <= 5'h00;
			switching_clock <= 1'b0;
		end else begin
			if (low_power_front_clock_sel) begin
				step = SW_LP_SRC_MHZ;
				limit = 13'(CLK_MHZ) * ({7'h00, charge_clock_divider} + SW_LP_DIV_OFS);
			end else begin
				step = SW_FAST_SRC_MHZ;
				limit = 13'(CLK_MHZ) * ({7'h00, charge_clock_divider} + SW_FAST_DIV_OFS);
			end
			sum = sw_acc + step;
			if (state == ST_IDLE) begin
				sw_acc <= 13'h0000;
				spread_cnt <= 5'h00;
				switching_clock <= 1'b0;
			end else if (front_clock_gate_off) begin
				switching_clock <= switching_clock;
			end else if (!low_power_front_clock_sel && charge_clock_divider >= DIV_SPREAD_LO) begin
				if (spread_cnt == 5'h00) begin
					// 9 + three random terms: 9..24 cycles, period 18..48, mean near 1.5 MHz
					spread_cnt <= SPREAD_HALF_BASE + {2'b00, lfsr[2:0]} + {2'b00, lfsr[5:3]}
						+ {4'h0, lfsr[6]} - 5'h01;
					switching_clock <= !switching_clock;
				end else begin
					spread_cnt <= spread_cnt - 5'h01;
				end
			end else if (sum >= limit) begin
				sw_acc <= sum - limit;
				switching_clock <= !switching_clock;
			end else begin
				sw_acc <= sum;
			end
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic [11:0] dis_len;
	logic [11:0] pre_len;
	// phase length helpers for the duration checks
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dis_len <= 12'h000;
			pre_len <= 12'h000;
		end else begin
			dis_len <= (state == ST_DISCH) ? dis_len + 12'h001 : 12'h000;
			pre_len <= (state == ST_PRECH) ? pre_len + 12'h001 : 12'h000;
		end
	end

	a_launch_starts: assert property (launch |=> scan_go && state == ST_DISCH)
		else $error("launch did not start a scan");
	a_done_clears_go: assert property (state == ST_DONE |=> !scan_go && state == ST_IDLE)
		else $error("go bit not cleared after scan");
	a_abort_stops: assert property (abort |=> state == ST_IDLE && !scan_go && !count_active)
		else $error("abort did not stop scan");
	a_dis_time: assert property (state == ST_PRECH && $past(state) == ST_DISCH |->
		dis_len == (initial_discharge_time_sel ? DISCH_LONG_CYC : DISCH_SHORT_CYC))
		else $error("pre-discharge length wrong");
	a_pre_time: assert property (state == ST_COUNT && $past(state) == ST_PRECH |->
		pre_len == (precharge_time_sel ? PRECH_LONG_CYC : PRECH_SHORT_CYC))
		else $error("precharge length wrong");
	a_raw_width: assert property (state == ST_DONE |=> (32'(raw_count) >> (WIDTH_BASE + 32'(count_width_sel))) == 0)
		else $error("raw count exceeds width");
	a_raw_holds: assert property (state != ST_DONE |=> $stable(raw_count))
		else $error("raw count changed outside scan end");
	a_irq_pulse: assert property (state == ST_DONE |=> scan_done_irq ##1 !scan_done_irq)
		else $error("completion request not a single pulse");
	a_gate_holds: assert property (front_clock_gate_off && $past(front_clock_gate_off) && state != ST_IDLE
		&& $past(state) != ST_IDLE |-> $stable(switching_clock))
		else $error("switching clock ran while gated");
	a_bad_chan: assert property (go_write && sfr_wdata[GO_BIT] && !scan_go && !parallel_scan && !chan_valid
		|=> !scan_go && state == ST_IDLE)
		else $error("invalid channel launched a scan");
	a_slow_tick: assert property (cnt_tick && count_clock_sel == 2'b11 && state == ST_COUNT
		|=> !cnt_tick [*8])
		else $error("4 MHz count clock too fast");

	c_full_scan: cover property (state == ST_COUNT ##1 state == ST_DONE ##1 scan_done_irq);
	c_abort: cover property (abort && state == ST_COUNT);
	c_parallel: cover property (launch && parallel_scan);
	c_spread: cover property (state != ST_IDLE && charge_clock_divider >= DIV_SPREAD_LO && $changed(switching_clock));
endmodule

// file: src/cts_pkg.sv
// Purpose: constants shared by the capacitive touch scan controller
// Assumes: 50 MHz system clock, 8-bit register buses
// Notes: times are kept in ns, cycle counts derived from them
package cts_pkg;
	// -----------------------------------------------------------------
	// clock and timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 50;
	localparam int unsigned DISCH_SHORT_NS = 2000;
	localparam int unsigned DISCH_LONG_NS = 10000;
	localparam int unsigned PRECH_SHORT_NS = 20000;
	localparam int unsigned PRECH_LONG_NS = 40000;
	localparam logic [11:0] DISCH_SHORT_CYC = 12'((DISCH_SHORT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] DISCH_LONG_CYC = 12'((DISCH_LONG_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] PRECH_SHORT_CYC = 12'((PRECH_SHORT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] PRECH_LONG_CYC = 12'((PRECH_LONG_NS * CLK_MHZ + 999) / 1000);
	// count clock rates in MHz, indexed by count_clock_sel
	localparam logic [6:0] CNT_RATE_0 = 7'h18;
	localparam logic [6:0] CNT_RATE_1 = 7'h0c;
	localparam logic [6:0] CNT_RATE_2 = 7'h06;
	localparam logic [6:0] CNT_RATE_3 = 7'h04;
	// switching clock sources (toggle rate = source / divisor)
	localparam logic [12:0] SW_FAST_SRC_MHZ = 13'h0060;
	localparam logic [12:0] SW_LP_SRC_MHZ = 13'h0018;
	localparam logic [12:0] SW_FAST_DIV_OFS = 13'h0008;
	localparam logic [12:0] SW_LP_DIV_OFS = 13'h0002;
	localparam logic [5:0] DIV_FIXED_MAX = 6'h3c;
	localparam logic [5:0] DIV_SPREAD_LO = 6'h3e;
	localparam logic [4:0] SPREAD_HALF_BASE = 5'h09;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam int unsigned WIDTH_BASE = 9;
	// -----------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] SFR_RAW_LOW = 8'hab;
	localparam logic [7:0] SFR_RAW_HIGH = 8'hac;
	localparam logic [7:0] SFR_SYS_CLK = 8'had;
	localparam logic [7:0] SFR_SCAN_GO = 8'hc9;
	localparam logic [7:0] SFR_PULLUP_LOW = 8'hca;
	localparam logic [7:0] SFR_SCAN_CFG1 = 8'hcb;
	localparam logic [7:0] SFR_SCAN_CFG2 = 8'hcc;
	localparam logic [7:0] SFR_SCAN_CFG3 = 8'hcd;
	localparam logic [7:0] SEC_PORT_0_7 = 8'h26;
	localparam logic [7:0] SEC_PORT_8_11 = 8'h27;
	localparam logic [7:0] SEC_PORT_16_23 = 8'h28;
	localparam logic [7:0] SEC_PORT_24_31 = 8'h29;
	localparam logic [7:0] SEC_ANA_CFG = 8'h2b;
	localparam logic [7:0] SEC_PWR_DOWN = 8'h2d;
	localparam logic [7:0] SEC_PORT_32_39 = 8'h51;
	localparam logic [7:0] SEC_PORT_40_47 = 8'h52;
	// -----------------------------------------------------------------
	// reset values, writable masks, field positions
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SCAN_CFG2 = 8'h80;
	localparam logic [7:0] RST_SCAN_CFG3 = 8'h70;
	localparam logic [7:0] RST_ANA_CFG = 8'h2f;
	localparam logic [7:0] RST_PWR_DOWN = 8'hff;
	localparam logic [7:0] MASK_SYS_CLK = 8'h3f;
	localparam logic [7:0] MASK_CFG1 = 8'h7f;
	localparam logic [7:0] MASK_CFG3 = 8'h7f;
	localparam logic [7:0] MASK_PORT_8_11 = 8'h0f;
	localparam logic [7:0] MASK_ANA_CFG = 8'h3f;
	localparam int unsigned GO_BIT = 0;
	localparam int unsigned LP_SEL_BIT = 5;
	localparam int unsigned GATE_OFF_BIT = 6;
	localparam int unsigned PULLUP_HIGH_BIT = 7;
	localparam int unsigned PARALLEL_BIT = 6;
	localparam int unsigned WIDTH_LSB = 4;
	localparam int unsigned CNT_CLK_LSB = 2;
	localparam int unsigned PRECH_BIT = 1;
	localparam int unsigned DISCH_BIT = 0;
	localparam int unsigned RES_LSB = 3;
	localparam int unsigned FRONT_PD_BIT = 1;
	localparam logic [5:0] CHAN_LOW_LAST = 6'h0b;
	localparam logic [5:0] CHAN_HIGH_FIRST = 6'h10;
	localparam logic [5:0] CHAN_HIGH_LAST = 6'h2f;
	// scan sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_DISCH = 5'b00010,
		ST_PRECH = 5'b00100,
		ST_COUNT = 5'b01000,
		ST_DONE = 5'b10000
	} cts_state_type;
endpackage

// file: sim/cts_electrode_model.sv
// Purpose: electrode and comparator stand-in for the touch scan controller
// Assumes: comparator output is high while a touched electrode is charged
// Notes: outside a scan the line wanders each cycle, so stale levels never help
`timescale 1ns/10ps
module cts_electrode_model (
	input wire logic clk,
	input wire logic scan_busy,
	input wire logic touched,
	output logic comparator_in
);
	// ------------------------------------------------------------------
	// comparator level
	// ------------------------------------------------------------------
	// steady during a scan, toggling noise when idle
	initial comparator_in = 1'b0;
	always @(posedge clk) begin
		comparator_in <= scan_busy ? touched : ~comparator_in;
	end
endmodule

// file: sim/testbench.sv
// Purpose: self-checking bench for the touch scan controller
// Assumes: 50 MHz clk, inputs driven at the falling edge
// Notes: short widths keep each scan within a few thousand cycles
`timescale 1ns/10ps
module testbench;
	import cts_pkg::*;
	logic clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, sec_wr = 0, sec_rd = 0, touched = 1, cmp;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sec_addr = 0, sec_wdata = 0, sfr_rdata, sec_rdata, rd_v;
	logic sw, dis, pre, cnt, pd, irq;
	logic [47:0] pe, mask;
	logic [8:0] pu;
	logic [2:0] rs, vt;
	int error_cnt = 0, n_tests = 0;
	cts_touch_scan u_cts_touch_scan (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sec_addr(sec_addr), .sec_wr(sec_wr),
		.sec_rd(sec_rd), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata), .comparator_in(cmp),
		.switching_clock(sw), .discharge_active(dis), .precharge_active(pre), .count_active(cnt),
		.electrode_port_enable(pe), .scan_channel_mask(mask), .pullup_code(pu), .series_resistor_sel(rs),
		.threshold_voltage_sel(vt), .touch_front_power_down(pd), .scan_done_irq(irq));
	cts_electrode_model u_cts_electrode_model (.clk(clk), .scan_busy(dis | pre | cnt), .touched(touched),
		.comparator_in(cmp));
	// ------------------------------------------------------------------
	// clock, bus tasks, checks
	// ------------------------------------------------------------------
	initial forever #10 clk = ~clk;
	task final_report();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write held across one rising edge
	task wr(input logic s, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		if (s) begin sec_addr = a; sec_wdata = d; sec_wr = 1; end
		else begin sfr_addr = a; sfr_wdata = d; sfr_wr = 1; end
		@(negedge clk);
		sfr_wr = 0; sec_wr = 0;
	endtask
	// read and compare, data taken one edge after the strobe
	task rc(input logic s, input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		if (s) begin sec_addr = a; sec_rd = 1; end
		else begin sfr_addr = a; sfr_rd = 1; end
		@(negedge clk);
		sfr_rd = 0; sec_rd = 0;
		rd_v = s ? sec_rdata : sfr_rdata;
		chk($sformatf("reg_%h", a), {8'h00, e}, {8'h00, rd_v});
	endtask
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task t_reset();
		rc(0, 8'hcc, 8'h80);
		rc(0, 8'hcd, 8'h70);
		rc(1, 8'h2b, 8'h2f);
		rc(1, 8'h2d, 8'hff);
		rc(0, 8'hac, 8'h00);
		rc(0, 8'h50, 8'h00);
		chk("pullup", 16'h0100, {7'h00, pu});
		chk("analog", 16'h0571, {5'h00, rs, 1'b0, vt, 3'h0, pd});
	endtask
	// one scan on channel 0, phases timed, count checked
	task t_scan(input logic [7:0] cfg3, input int nd, input int np, input int lo, input logic [15:0] raw, input logic t);
		int d, p, c, k;
		d = 0; p = 0; c = 0;
		touched = t;
		wr(0, 8'hcd, cfg3);
		wr(1, 8'h26, 8'h01);
		wr(0, 8'hcc, 8'h00);
		wr(0, 8'hc9, 8'h01);
		chk("mask", 16'h0001, mask[15:0]);
		for (k = 0; k < 20000 && irq !== 1'b1; k++) begin
			d += dis; p += pre; c += cnt;
			@(negedge clk);
		end
		if (k == 20000) begin error_cnt++; final_report(); end
		chk("dis_len", nd, d);
		chk("pre_len", np, p);
		chk("cnt_len", 1, c >= lo - 2 && c <= lo + 8);
		rc(0, 8'hc9, 8'h00);
		rc(0, 8'hab, raw[7:0]);
		rc(0, 8'hac, raw[15:8]);
	endtask
	// abort in the count phase with hits pending; raw count must not move
	task t_abort();
		int k;
		logic seen;
		seen = 0;
		touched = 1;
		wr(0, 8'hc9, 8'h01);
		repeat (1200) @(negedge clk);
		chk("counting", 16'h0001, {15'h0000, cnt});
		wr(0, 8'hc9, 8'h00);
		chk("phases", 16'h0000, {dis, pre, cnt, mask[0]});
		for (k = 0; k < 10; k++) begin seen |= irq; @(negedge clk); end
		chk("abort_irq", 16'h0000, {15'h0000, seen});
		rc(0, 8'hab, 8'h00);
	endtask
	// launch, time switching clock half periods over 1000 cycles, abort
	task t_sw(input logic [7:0] sc, input logic [7:0] c1, input int lo, hi, rmin, rmax);
		int k, tg, run, mn, mx;
		logic ps;
		tg = 0; run = 0; mn = 1000; mx = 0;
		wr(0, 8'had, sc);
		wr(0, 8'hcb, c1);
		wr(0, 8'hc9, 8'h01);
		ps = sw;
		for (k = 0; k < 1000; k++) begin
			@(negedge clk);
			run++;
			if (sw !== ps) begin
				tg++;
				if (tg > 1) begin mn = run < mn ? run : mn; mx = run > mx ? run : mx; end
				run = 0;
			end
			ps = sw;
		end
		chk("sw_rate", 16'h0001, {15'h0000, tg >= lo && tg <= hi && !$isunknown(sw)});
		chk("sw_half", 16'h0001, {15'h0000, tg < 3 || (mn >= rmin && mx <= rmax)});
		wr(0, 8'hc9, 8'h00);
	endtask
	task t_refuse();
		wr(0, 8'hcc, 8'h0c);
		wr(0, 8'hc9, 8'h01);
		rc(0, 8'hc9, 8'h00);
		wr(0, 8'hab, 8'h55);
		rc(0, 8'hab, 8'h00);
		wr(1, 8'h27, 8'hff);
		rc(1, 8'h27, 8'h0f);
		chk("port_en", 16'h0f01, pe[15:0]);
		wr(0, 8'hcc, 8'h4c);
		wr(0, 8'hc9, 8'h01);
		chk("par_mask", 16'h0f01, mask[15:0]);
		wr(0, 8'hc9, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 0;
		t_reset();
		t_scan(8'h00, 100, 1000, 1066, 16'h01ff, 1);
		t_scan(8'h17, 500, 2000, 4266, 16'h03ff, 1);
		t_scan(8'h0c, 100, 1000, 6400, 16'h0000, 0);
		t_abort();
		t_sw(8'h00, 8'h00, 239, 241, 4, 5);
		t_sw(8'h20, 8'h01, 159, 161, 6, 7);
		t_sw(8'h00, 8'h3e, 40, 112, 9, 24);
		t_sw(8'h00, 8'h40, 0, 0, 0, 1000);
		t_refuse();
		final_report();
	end
endmodule
